// [inc/ccr_pkg.sv]
// Purpose: shared constants for the converter control register bank
// Assumes: 8-bit registers reached through the serial interface's register port
// Notes: reset defaults are variant dependent and overridable per instance
package ccr_pkg;
    // register byte offsets
    localparam logic [7:0] CCR_OFF_CONV4 = 8'h25;
    localparam logic [7:0] CCR_OFF_CONV5 = 8'h26;
    localparam logic [7:0] CCR_OFF_CONV6 = 8'h27;

    // field positions inside each control register
    localparam int CCR_SLP_HI = 5;
    localparam int CCR_SLP_LO = 4;
    localparam int CCR_RSV_HI = 3;
    localparam int CCR_RSV_LO = 2;
    localparam int CCR_MODE_BIT = 1;
    localparam int CCR_EN_BIT = 0;
    localparam int CCR_RO_HI = 7;
    localparam int CCR_RO_LO = 6;

    // sleep-select encodings; the other two are reserved
    localparam logic [1:0] CCR_SLP_OFF = 2'h0;
    localparam logic [1:0] CCR_SLP_ON = 2'h3;
    localparam logic [1:0] CCR_RSV_VAL = 2'h3;
    localparam logic [1:0] CCR_RO_VAL = 2'h0;

    // bits software can change; top two read zero
    localparam logic [7:0] CCR_WR_MASK = 8'h3f;
    localparam logic [7:0] CCR_RD_IDLE = 8'h00;

    // default reset contents, one variant's factory image
    localparam logic [7:0] CCR_RST_CONV4 = 8'h0f;
    localparam logic [7:0] CCR_RST_CONV5 = 8'h0f;
    localparam logic [7:0] CCR_RST_CONV6 = 8'h0d;

    // control input pins and the two that double as sleep inputs
    localparam int CCR_NUM_CTL = 6;
    localparam int CCR_IDX_SLEEP_ONE = 2;
    localparam int CCR_IDX_SLEEP_TWO = 5;
    localparam int CCR_VCODE_W = 7;

    typedef enum logic [0:0] {
        CCR_PIN_ONE = 1'b0,
        CCR_PIN_TWO = 1'b1
    } ccr_pin_e;

    typedef enum logic [0:0] {
        CCR_MODE_AUTO = 1'b0,
        CCR_MODE_PWM = 1'b1
    } ccr_mode_e;
endpackage

// [verilog/ccr_conv_lane.sv]
// Purpose: one converter control register and its steering outputs
// Assumes: all inputs synchronous to sys_clk
// Notes: outputs are registered, so effects lag their cause by one clock, and a register write reaches the controls two clocks later
`timescale 1ns/10ps
module ccr_conv_lane #(
    parameter logic [7:0] RESET_VAL = ccr_pkg::CCR_RST_CONV4,
    parameter ccr_pkg::ccr_pin_e SLEEP_PIN = ccr_pkg::CCR_PIN_ONE,
    parameter int VCODE_W = ccr_pkg::CCR_VCODE_W
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // register write port
    input wire logic wr_en,
    input wire logic [7:0] wr_data,
    // pins and codes
    input wire logic sleep_one,
    input wire logic sleep_two,
    input wire logic pin_request,
    input wire logic [VCODE_W-1:0] normal_code,
    input wire logic [VCODE_W-1:0] sleep_code,
    // register contents and converter controls
    output logic [7:0] ctrl_r,
    output logic [VCODE_W-1:0] vcode_r,
    output logic pwm_r,
    output logic on_r,
    output logic sleep_r
);
    import ccr_pkg::*;

    logic sleep_pin;
    logic sleep_now;

    // a reset image with a reserved select code, live top bits or cleared
    // reserved bits is refused, so a bad factory image fails at build time
    if (RESET_VAL[CCR_RO_HI:CCR_RO_LO] != CCR_RO_VAL ||
        RESET_VAL[CCR_RSV_HI:CCR_RSV_LO] != CCR_RSV_VAL ||
        (RESET_VAL[CCR_SLP_HI:CCR_SLP_LO] != CCR_SLP_OFF &&
         RESET_VAL[CCR_SLP_HI:CCR_SLP_LO] != CCR_SLP_ON)) begin : g_bad_reset
        $error("illegal reset image for converter control register");
    end

    // storage; top bits masked so they can never be set
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ctrl_r <= RESET_VAL;
        end else if (wr_en) begin
            ctrl_r <= wr_data & CCR_WR_MASK;
        end
    end

    // sleep pin is fixed by configuration, never by software
    assign sleep_pin = (SLEEP_PIN == CCR_PIN_TWO) ? sleep_two : sleep_one;
    // only 11 arms sleep; reserved codes fall back to the normal code
    assign sleep_now = (ctrl_r[CCR_SLP_HI:CCR_SLP_LO] == CCR_SLP_ON) && !sleep_pin;

    // converter controls, refreshed every clock
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            vcode_r <= '0;
            pwm_r <= 1'b0;
            on_r <= 1'b0;
            sleep_r <= 1'b0;
        end else begin
            vcode_r <= sleep_now ? sleep_code : normal_code;
            pwm_r <= ctrl_r[CCR_MODE_BIT];
            on_r <= ctrl_r[CCR_EN_BIT] & pin_request;
            sleep_r <= sleep_now;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence s_wr_pwm;
        wr_en && wr_data[CCR_MODE_BIT];
    endsequence
    sequence s_pwm_seen;
        ##1 ctrl_r[CCR_MODE_BIT] ##1 pwm_r;
    endsequence

    property p_sleep_off;
        ctrl_r[CCR_SLP_HI:CCR_SLP_LO] == CCR_SLP_OFF |=> vcode_r == $past(normal_code);
    endproperty
    a_sleep_off: assert property (p_sleep_off) else $error("normal code not used");
    property p_sleep_low;
        ctrl_r[CCR_SLP_HI:CCR_SLP_LO] == CCR_SLP_ON && !sleep_pin
            |=> vcode_r == $past(sleep_code) && sleep_r;
    endproperty
    a_sleep_low: assert property (p_sleep_low) else $error("sleep code not used");
    property p_mode;
        s_wr_pwm |-> s_pwm_seen;
    endproperty
    a_mode: assert property (p_mode) else $error("forced pwm not applied");
    property p_off;
        !ctrl_r[CCR_EN_BIT] |=> !on_r;
    endproperty
    a_off: assert property (p_off) else $error("converter not forced off");
    property p_ro_zero;
        ctrl_r[CCR_RO_HI:CCR_RO_LO] == CCR_RO_VAL;
    endproperty
    a_ro_zero: assert property (p_ro_zero) else $error("read-only bits set");
endmodule // ccr_conv_lane

// [verilog/converter_ctrl_regs.sv]
// Purpose: control register bank for converters four, five and six
// Assumes: register port driven by the serial interface engine, one access per strobe
// Notes: reset contents and sleep pin choice are factory parameters
`timescale 1ns/10ps
// Functional notes
// - select code 00 always uses the normal voltage code.
// - select code 11 uses the sleep code while the assigned pin is low.
// - each converter follows one sleep pin fixed at configuration.
// - bit 1 low gives automatic mode, high gives forced pwm.
// - bit 0 low forces the converter off over all control pins.
// - same layout for converters four to six at 25h, 26h, 27h.
module converter_ctrl_regs #(
    parameter logic [7:0] CONV4_RESET = ccr_pkg::CCR_RST_CONV4,
    parameter logic [7:0] CONV5_RESET = ccr_pkg::CCR_RST_CONV5,
    parameter logic [7:0] CONV6_RESET = ccr_pkg::CCR_RST_CONV6,
    parameter ccr_pkg::ccr_pin_e CONV4_SLEEP_PIN = ccr_pkg::CCR_PIN_ONE,
    parameter ccr_pkg::ccr_pin_e CONV5_SLEEP_PIN = ccr_pkg::CCR_PIN_ONE,
    parameter ccr_pkg::ccr_pin_e CONV6_SLEEP_PIN = ccr_pkg::CCR_PIN_ONE,
    parameter int VCODE_W = ccr_pkg::CCR_VCODE_W
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // register port from the serial interface
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    // control input pins
    input wire logic [ccr_pkg::CCR_NUM_CTL-1:0] control_inputs,
    // enable requests decoded from the control pins
    input wire logic conv4_pin_request,
    input wire logic conv5_pin_request,
    input wire logic conv6_pin_request,
    // voltage codes held elsewhere
    input wire logic [VCODE_W-1:0] conv4_normal_voltage_code,
    input wire logic [VCODE_W-1:0] conv4_sleep_voltage_code,
    input wire logic [VCODE_W-1:0] conv5_normal_voltage_code,
    input wire logic [VCODE_W-1:0] conv5_sleep_voltage_code,
    input wire logic [VCODE_W-1:0] conv6_normal_voltage_code,
    input wire logic [VCODE_W-1:0] conv6_sleep_voltage_code,
    // converter four controls
    output logic [VCODE_W-1:0] conv4_vcode,
    output logic conv4_pwm,
    output logic conv4_on,
    output logic conv4_sleep_active,
    // converter five controls
    output logic [VCODE_W-1:0] conv5_vcode,
    output logic conv5_pwm,
    output logic conv5_on,
    output logic conv5_sleep_active,
    // converter six controls
    output logic [VCODE_W-1:0] conv6_vcode,
    output logic conv6_pwm,
    output logic conv6_on,
    output logic conv6_sleep_active
);
    import ccr_pkg::*;

    if (VCODE_W < 1 || VCODE_W > 8) begin : g_bad_width
        $error("voltage code width out of range");
    end

    logic [7:0] conv4_ctrl;
    logic [7:0] conv5_ctrl;
    logic [7:0] conv6_ctrl;
    logic hit4;
    logic hit5;
    logic hit6;
    logic sleep_one;
    logic sleep_two;
    logic [1:0] conv4_sleep_select;
    logic [1:0] conv5_sleep_select;
    logic [1:0] conv6_sleep_select;
    logic [7:0] rdata_nxt;

    // address decode; one register per byte offset
    assign hit4 = (reg_addr == CCR_OFF_CONV4);
    assign hit5 = (reg_addr == CCR_OFF_CONV5);
    assign hit6 = (reg_addr == CCR_OFF_CONV6);

    // the third and sixth control inputs double as the sleep inputs
    assign sleep_one = control_inputs[CCR_IDX_SLEEP_ONE];
    assign sleep_two = control_inputs[CCR_IDX_SLEEP_TWO];

    // field views for the sleep-pin checks
    assign conv4_sleep_select = conv4_ctrl[CCR_SLP_HI:CCR_SLP_LO];
    assign conv5_sleep_select = conv5_ctrl[CCR_SLP_HI:CCR_SLP_LO];
    assign conv6_sleep_select = conv6_ctrl[CCR_SLP_HI:CCR_SLP_LO];

    // converter four
    ccr_conv_lane #(
        .RESET_VAL(CONV4_RESET),
        .SLEEP_PIN(CONV4_SLEEP_PIN),
        .VCODE_W(VCODE_W)
    ) u_conv4 (
        .sys_clk(sys_clk),
        .rst(rst),
        .wr_en(reg_wr && hit4),
        .wr_data(reg_wdata),
        .sleep_one(sleep_one),
        .sleep_two(sleep_two),
        .pin_request(conv4_pin_request),
        .normal_code(conv4_normal_voltage_code),
        .sleep_code(conv4_sleep_voltage_code),
        .ctrl_r(conv4_ctrl),
        .vcode_r(conv4_vcode),
        .pwm_r(conv4_pwm),
        .on_r(conv4_on),
        .sleep_r(conv4_sleep_active)
    );

    // converter five
    ccr_conv_lane #(
        .RESET_VAL(CONV5_RESET),
        .SLEEP_PIN(CONV5_SLEEP_PIN),
        .VCODE_W(VCODE_W)
    ) u_conv5 (
        .sys_clk(sys_clk),
        .rst(rst),
        .wr_en(reg_wr && hit5),
        .wr_data(reg_wdata),
        .sleep_one(sleep_one),
        .sleep_two(sleep_two),
        .pin_request(conv5_pin_request),
        .normal_code(conv5_normal_voltage_code),
        .sleep_code(conv5_sleep_voltage_code),
        .ctrl_r(conv5_ctrl),
        .vcode_r(conv5_vcode),
        .pwm_r(conv5_pwm),
        .on_r(conv5_on),
        .sleep_r(conv5_sleep_active)
    );

    // converter six
    ccr_conv_lane #(
        .RESET_VAL(CONV6_RESET),
        .SLEEP_PIN(CONV6_SLEEP_PIN),
        .VCODE_W(VCODE_W)
    ) u_conv6 (
        .sys_clk(sys_clk),
        .rst(rst),
        .wr_en(reg_wr && hit6),
        .wr_data(reg_wdata),
        .sleep_one(sleep_one),
        .sleep_two(sleep_two),
        .pin_request(conv6_pin_request),
        .normal_code(conv6_normal_voltage_code),
        .sleep_code(conv6_sleep_voltage_code),
        .ctrl_r(conv6_ctrl),
        .vcode_r(conv6_vcode),
        .pwm_r(conv6_pwm),
        .on_r(conv6_on),
        .sleep_r(conv6_sleep_active)
    );

    // read mux; reserved bits 3:2 read back whatever software stored
    always_comb begin
        rdata_nxt = CCR_RD_IDLE;
        if (hit4) begin
            rdata_nxt = conv4_ctrl & CCR_WR_MASK;
        end else if (hit5) begin
            rdata_nxt = conv5_ctrl & CCR_WR_MASK;
        end else if (hit6) begin
            rdata_nxt = conv6_ctrl & CCR_WR_MASK;
        end
    end

    // read data held until the next read so the serializer can take it late
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= CCR_RD_IDLE;
        end else if (reg_rd) begin
            reg_rdata <= rdata_nxt;
        end
    end

    // one-cycle answer strobe, also given for unmapped offsets
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence s_rd4;
        reg_rd && hit4;
    endsequence
    sequence s_wr5_only;
        reg_wr && hit5;
    endsequence

    property p_rd4;
        s_rd4 |=> reg_rvalid && reg_rdata == {CCR_RO_VAL, $past(conv4_ctrl[CCR_SLP_HI:CCR_EN_BIT])};
    endproperty
    a_rd4: assert property (p_rd4) else $error("converter four read-back wrong");
    property p_unmapped;
        reg_rd && !hit4 && !hit5 && !hit6 |=> reg_rvalid && reg_rdata == CCR_RD_IDLE;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_rvalid;
        !reg_rd |=> !reg_rvalid;
    endproperty
    a_rvalid: assert property (p_rvalid) else $error("stray read strobe");
    property p_wr_isolated;
        s_wr5_only |=> $stable(conv4_ctrl) && $stable(conv6_ctrl);
    endproperty
    a_wr_isolated: assert property (p_wr_isolated) else $error("write hit wrong lane");
    property p_wr_lands;
        reg_wr && hit6 |=> conv6_ctrl == ($past(reg_wdata) & CCR_WR_MASK) ##1
            conv6_pwm == $past(conv6_ctrl[CCR_MODE_BIT]);
    endproperty
    a_wr_lands: assert property (p_wr_lands) else $error("write not applied");
    // a lane on the second sleep input must ignore the first one
    property p_pin_follow;
        conv6_sleep_select == CCR_SLP_ON && CONV6_SLEEP_PIN == CCR_PIN_TWO && sleep_two
            |=> !conv6_sleep_active && conv6_vcode == $past(conv6_normal_voltage_code);
    endproperty
    a_pin_follow: assert property (p_pin_follow) else $error("wrong sleep pin");
    // converters four and five, when on the first sleep input, must enter sleep when it goes low
    property p_pin_one4;
        conv4_sleep_select == CCR_SLP_ON && CONV4_SLEEP_PIN == CCR_PIN_ONE && !sleep_one
            |=> conv4_sleep_active && conv4_vcode == $past(conv4_sleep_voltage_code);
    endproperty
    a_pin_one4: assert property (p_pin_one4) else $error("four missed sleep pin");
    property p_pin_one5;
        conv5_sleep_select == CCR_SLP_ON && CONV5_SLEEP_PIN == CCR_PIN_ONE && !sleep_one
            |=> conv5_sleep_active && conv5_vcode == $past(conv5_sleep_voltage_code);
    endproperty
    a_pin_one5: assert property (p_pin_one5) else $error("five missed sleep pin");
    property p_rd_ro;
        reg_rvalid |-> reg_rdata[CCR_RO_HI:CCR_RO_LO] == CCR_RO_VAL;
    endproperty
    a_rd_ro: assert property (p_rd_ro) else $error("top bits read nonzero");
    property p_on6;
        conv6_ctrl[CCR_EN_BIT] && conv6_pin_request |=> conv6_on;
    endproperty
    a_on6: assert property (p_on6) else $error("enabled converter not on");
endmodule // converter_ctrl_regs

// [verif/converter_ctrl_regs_tb.sv]
// Purpose: self-checking bench for the converter control register bank
// Assumes: register port strobes last one cycle and read answers come one edge later
// Notes: converter six follows sleep input two so the pin choice is exercised
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin errors++; \
    $display("unexpected %s expected %h seen %h", nm, ex, got); end end

module converter_ctrl_regs_tb;
    import ccr_pkg::*;
    localparam int VW = CCR_VCODE_W;
    localparam int LIMIT = 4000;
    logic sys_clk;
    logic rst;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [7:0] reg_rdata;
    logic reg_rvalid;
    logic [5:0] control_inputs;
    logic [2:0] pin_req;
    logic [VW-1:0] nc [3];
    logic [VW-1:0] sc [3];
    logic [VW-1:0] vc [3];
    logic [2:0] pwm;
    logic [2:0] on;
    logic [2:0] slp;
    logic [7:0] shadow [3];
    logic [7:0] offs [3] = '{CCR_OFF_CONV4, CCR_OFF_CONV5, CCR_OFF_CONV6};
    int pin_idx [3] = '{CCR_IDX_SLEEP_ONE, CCR_IDX_SLEEP_ONE, CCR_IDX_SLEEP_TWO};
    int errors = 0;
    int checked = 0;
    int cycles = 0;

    // device under test, converter six on the second sleep input
    converter_ctrl_regs #(
        .CONV6_SLEEP_PIN(CCR_PIN_TWO)
    ) u_dut (
        .sys_clk(sys_clk),
        .rst(rst),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid),
        .control_inputs(control_inputs),
        .conv4_pin_request(pin_req[0]),
        .conv5_pin_request(pin_req[1]),
        .conv6_pin_request(pin_req[2]),
        .conv4_normal_voltage_code(nc[0]),
        .conv4_sleep_voltage_code(sc[0]),
        .conv5_normal_voltage_code(nc[1]),
        .conv5_sleep_voltage_code(sc[1]),
        .conv6_normal_voltage_code(nc[2]),
        .conv6_sleep_voltage_code(sc[2]),
        .conv4_vcode(vc[0]),
        .conv4_pwm(pwm[0]),
        .conv4_on(on[0]),
        .conv4_sleep_active(slp[0]),
        .conv5_vcode(vc[1]),
        .conv5_pwm(pwm[1]),
        .conv5_on(on[1]),
        .conv5_sleep_active(slp[1]),
        .conv6_vcode(vc[2]),
        .conv6_pwm(pwm[2]),
        .conv6_on(on[2]),
        .conv6_sleep_active(slp[2])
    );

    // 40 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    // inputs move on the falling edge so the rising edge sees them settled
    task automatic tick();
        @(negedge sys_clk);
    endtask

    // one-cycle write strobe; outputs reflect it once this returns
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        tick();
        reg_wr = 1'b0;
        tick();
    endtask

    // one-cycle read strobe, answer checked the cycle after
    task automatic rd(input logic [7:0] a, input logic [7:0] ex);
        reg_addr = a;
        reg_rd = 1'b1;
        tick();
        reg_rd = 1'b0;
        `CHK("read answer", 1'b1, reg_rvalid)
        `CHK("read data", ex, reg_rdata)
        tick();
        `CHK("read answer end", 1'b0, reg_rvalid)
        `CHK("read data held", ex, reg_rdata)
    endtask

    // sleep pins and pin requests in one step each, no glitching
    task automatic set_pins(input logic [1:0] p);
        control_inputs = {p[1], 2'b11, p[0], 2'b11};
        pin_req = {3{p[0] ^ p[1]}};
    endtask

    // expected converter controls worked out from the shadow contents
    task automatic check_all();
        logic s;
        for (int n = 0; n < 3; n++) begin
            s = (shadow[n][5:4] == CCR_SLP_ON) && !control_inputs[pin_idx[n]];
            `CHK("sleep flag", s, slp[n])
            `CHK("voltage code", s ? sc[n] : nc[n], vc[n])
            `CHK("mode", shadow[n][1], pwm[n])
            `CHK("run", shadow[n][0] & pin_req[n], on[n])
        end
    endtask

    task automatic conclude();
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // hang guard, far above the few hundred cycles the tests need
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            errors++;
            $display("unexpected cycle count expected %0d seen %0d", LIMIT - 1, cycles);
            conclude();
        end
    end

    initial begin
        logic [7:0] d;
        rst = 1'b1;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        set_pins(2'h3);
        nc = '{7'h11, 7'h12, 7'h13};
        sc = '{7'h61, 7'h62, 7'h63};
        shadow = '{CCR_RST_CONV4, CCR_RST_CONV5, CCR_RST_CONV6};
        repeat (2) tick();
        rst = 1'b0;
        tick();
        check_all();
        for (int n = 0; n < 3; n++) begin
            rd(offs[n], shadow[n]);
        end
        // every legal field combination on every converter, all pin states
        for (int n = 0; n < 3; n++) begin
            for (int v = 0; v < 8; v++) begin
                d = {2'b11, {2{v[2]}}, CCR_RSV_VAL, v[1], v[0]};
                wr(offs[n], d);
                shadow[n] = d & CCR_WR_MASK;
                check_all();
                rd(offs[n], shadow[n]);
                for (int p = 0; p < 4; p++) begin
                    set_pins(2'(p));
                    tick();
                    check_all();
                end
            end
        end
        // neighbours of the bank are unmapped: writes ignored, reads zero
        wr(8'h24, 8'h00);
        wr(8'h28, 8'h00);
        rd(8'h24, CCR_RD_IDLE);
        rd(8'h28, CCR_RD_IDLE);
        for (int n = 0; n < 3; n++) begin
            rd(offs[n], shadow[n]);
        end
        // reset in mid-run clears outputs and restores factory contents
        rst = 1'b1;
        tick();
        `CHK("codes in reset", 21'h0, {vc[0], vc[1], vc[2]})
        `CHK("controls in reset", 9'h0, {pwm, on, slp})
        `CHK("port in reset", 9'h0, {reg_rvalid, reg_rdata})
        rst = 1'b0;
        shadow = '{CCR_RST_CONV4, CCR_RST_CONV5, CCR_RST_CONV6};
        tick();
        check_all();
        for (int n = 0; n < 3; n++) begin
            rd(offs[n], shadow[n]);
        end
        conclude();
    end
endmodule // converter_ctrl_regs_tb
